// >>> dv/qec_counter_tb.sv
`timescale 1ns/1ps
module qec_counter_tb;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic [4:0] addr = 5'h00;
   logic rd_en = 1'b0;
   logic wr_en = 1'b0;
   logic [31:0] wdata = 32'h0000_0000;
   logic [3:0] be = 4'hf;
   logic [31:0] rdata;
   logic waitreq;
   logic [3:0] plain = 4'h0;
   logic [3:0] enc_lines;
   logic [7:0] dig_in;
   logic irq_req;
   logic [2:0] irq_source;
   int n_fail = 0;
   int samples_checked = 0;
   int irq_n = 0;
   always #12.5 clk_sys = ~clk_sys;
   qec_counter qec_counter_i (
      .CLK_SYS(clk_sys), .RESET(reset), .AVS_ADDRESS(addr), .AVS_READ(rd_en),
      .AVS_WRITE(wr_en), .AVS_BYTEENABLE(be), .AVS_WRITEDATA(wdata),
      .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq), .DIN({plain, enc_lines}),
      .DIG_IN(dig_in), .IRQ_REQ(irq_req), .IRQ_SOURCE(irq_source)
   );
   qec_encoder_model qec_encoder_model_i (.clk(clk_sys), .lines(enc_lines));
   // irq is a one-cycle pulse, so it is counted at every falling edge
   always @(negedge clk_sys) begin
      if (irq_req === 1'b1) begin
         irq_n++;
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                      input logic [3:0] m, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk_sys);
      addr <= a;
      rd_en <= ~w;
      wr_en <= w;
      wdata <= d;
      be <= m;
      // waitrequest and read data are taken as they stand at the rising edge
      do begin
         @(posedge clk_sys);
         n++;
      end while (waitreq !== 1'b0 && n < 100);
      if (n >= 100) begin
         n_fail++;
         $display("BAD t=%0t bus answer missing", $time);
      end
      q = rdata;
      rd_en <= 1'b0;
      wr_en <= 1'b0;
   endtask
   task automatic wr_be(input logic [4:0] a, input logic [31:0] d, input logic [3:0] m);
      logic [31:0] q;
      bus(1'b1, a, d, m, q);
   endtask
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      wr_be(a, d, 4'hf);
   endtask
   task automatic rd(input logic [4:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 32'h0000_0000, 4'hf, q);
      chk(q, exp);
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk_sys);
      n_fail++;
      report_and_stop();
   end
   initial begin
      repeat (2) @(posedge clk_sys);
      reset <= 1'b0;
      rd(qec_pkg::ADDR_CONFIG, qec_pkg::CONFIG_RESET);
      rd(qec_pkg::ADDR_SETPOINT, qec_pkg::SETPOINT_RESET);
      rd(5'h1c, 32'h0000_0000);
      plain <= 4'ha;
      repeat (3) @(posedge clk_sys);
      chk({24'h0, dig_in}, 32'h0000_00a0);
      // encoder mode, hardware window
      wr(qec_pkg::ADDR_CONFIG, 32'h0000_0009);
      plain <= 4'h5;
      qec_encoder_model_i.window(1'b1);
      chk({24'h0, dig_in}, 32'h0000_0050);
      qec_encoder_model_i.window(1'b0);
      wr(qec_pkg::ADDR_CONTROL, 32'h0000_0040);
      qec_encoder_model_i.step(3);
      rd(qec_pkg::ADDR_COUNT_LO, 32'h0000_0003);
      rd(qec_pkg::ADDR_STATUS, 32'h0000_0000);
      qec_encoder_model_i.step(-4);
      rd(qec_pkg::ADDR_COUNT_LO, 32'h0000_ffff);
      rd(qec_pkg::ADDR_COUNT_HI, 32'h0000_ffff);
      rd(qec_pkg::ADDR_STATUS, 32'h0000_0002);
      wr(qec_pkg::ADDR_CONTROL, 32'h0000_0048);
      wr(qec_pkg::ADDR_CONTROL, 32'h0000_0040);
      rd(qec_pkg::ADDR_STATUS, 32'h0000_0000);
      wr(qec_pkg::ADDR_CONTROL, 32'h0000_0000);
      qec_encoder_model_i.step(5);
      rd(qec_pkg::ADDR_COUNT_LO, 32'h0000_ffff);
      wr(qec_pkg::ADDR_CONTROL, 32'h0000_0040);
      qec_encoder_model_i.clash();
      rd(qec_pkg::ADDR_STATUS, 32'h0000_0008);
      wr(qec_pkg::ADDR_CONTROL, 32'h0000_0060);
      wr(qec_pkg::ADDR_CONTROL, 32'h0000_0040);
      rd(qec_pkg::ADDR_STATUS, 32'h0000_0000);
      wr(qec_pkg::ADDR_REF_VALUE, 32'h0001_2345);
      qec_encoder_model_i.window(1'b1);
      rd(qec_pkg::ADDR_STATUS, 32'h0000_0010);
      qec_encoder_model_i.window(1'b0);
      qec_encoder_model_i.reference();
      rd(qec_pkg::ADDR_STATUS, 32'h0000_0001);
      rd(qec_pkg::ADDR_COUNT_LO, 32'h0000_2345);
      rd(qec_pkg::ADDR_COUNT_HI, 32'h0000_0001);
      wr_be(qec_pkg::ADDR_REF_VALUE, 32'hffff_ffff, 4'h4);
      rd(qec_pkg::ADDR_REF_VALUE, 32'h00ff_2345);
      qec_encoder_model_i.step(1);
      wr(qec_pkg::ADDR_CONTROL, 32'h0000_0042);
      wr(qec_pkg::ADDR_CONTROL, 32'h0000_0040);
      rd(qec_pkg::ADDR_COUNT_LO, 32'h0000_2345);
      rd(qec_pkg::ADDR_COUNT_HI, 32'h0000_00ff);
      // software window: the hardware window pin must be ignored
      wr(qec_pkg::ADDR_CONFIG, 32'h0000_0005);
      qec_encoder_model_i.step(2);
      qec_encoder_model_i.window(1'b1);
      rd(qec_pkg::ADDR_STATUS, 32'h0000_0001);
      qec_encoder_model_i.window(1'b0);
      qec_encoder_model_i.reference();
      rd(qec_pkg::ADDR_COUNT_LO, 32'h0000_2347);
      wr(qec_pkg::ADDR_CONTROL, 32'h0000_0041);
      rd(qec_pkg::ADDR_STATUS, 32'h0000_0011);
      // one 32-bit up/down counter with setpoint interrupt
      wr(qec_pkg::ADDR_SETPOINT, 32'h0000_0002);
      wr(qec_pkg::ADDR_CONFIG, 32'h0000_0052);
      repeat (2) @(posedge clk_sys);
      chk({29'h0, irq_source}, 32'h0000_0005);
      wr(qec_pkg::ADDR_CONTROL, 32'h0000_0042);
      wr(qec_pkg::ADDR_CONTROL, 32'h0000_0040);
      irq_n = 0;
      qec_encoder_model_i.pulse(1'b1);
      qec_encoder_model_i.pulse(1'b1);
      rd(qec_pkg::ADDR_COUNT_LO, 32'h0000_0002);
      chk(irq_n, 32'h0000_0001);
      qec_encoder_model_i.pulse(1'b0);
      rd(qec_pkg::ADDR_COUNT_LO, 32'h0000_0001);
      chk(irq_n, 32'h0000_0001);
      // two 16-bit counters: pulses on inputs 0 and 2, direction on 1 and 3
      wr(qec_pkg::ADDR_SETPOINT, 32'h0001_0000);
      wr(qec_pkg::ADDR_CONFIG, 32'h0000_0003);
      wr(qec_pkg::ADDR_CONTROL, 32'h0000_0006);
      wr(qec_pkg::ADDR_CONTROL, 32'h0000_00c0);
      qec_encoder_model_i.pulse(1'b0);
      qec_encoder_model_i.pulse1(1'b1);
      rd(qec_pkg::ADDR_COUNT_LO, 32'h0000_ffff);
      rd(qec_pkg::ADDR_COUNT_HI, 32'h0000_0001);
      chk(irq_n, 32'h0000_0002);
      report_and_stop();
   end
endmodule

// >>> dv/qec_encoder_model.sv
`timescale 1ns/1ps
module qec_encoder_model (
   // clock
   input wire logic clk,
   // encoder lines: window, marker, phase b, phase a
   output logic [3:0] lines
);
   int ph;
   logic [1:0] gray [4];
   initial begin
      lines = 4'h0;
      ph = 0;
      gray = '{2'b00, 2'b01, 2'b11, 2'b10};
   end
   // n gray steps per call (backwards when n is negative), lines held three cycles so each change is seen alone
   task automatic step(input int n);
      repeat ((n < 0) ? -n : n) begin
         ph = (ph + 4 + ((n < 0) ? -1 : 1)) % 4;
         @(posedge clk) lines[1:0] <= gray[ph];
         repeat (2) @(posedge clk);
      end
   endtask
   // both phases flip in one cycle, which a healthy encoder never does
   task automatic clash();
      ph = (ph + 2) % 4;
      @(posedge clk) lines[1:0] <= gray[ph];
      repeat (3) @(posedge clk);
   endtask
   task automatic window(input logic v);
      @(posedge clk) lines[3] <= v;
      repeat (3) @(posedge clk);
   endtask
   // window opens around a single marker pulse only
   task automatic reference();
      @(posedge clk) lines[3] <= 1'b1;
      repeat (3) @(posedge clk);
      lines[2] <= 1'b1;
      repeat (2) @(posedge clk);
      lines[2] <= 1'b0;
      repeat (2) @(posedge clk);
      lines[3] <= 1'b0;
      repeat (3) @(posedge clk);
   endtask
   // counter mode: direction level on line 1, count pulse on line 0
   task automatic pulse(input logic dir);
      @(posedge clk) lines[0] <= 1'b0;
      lines[1] <= dir;
      repeat (2) @(posedge clk);
      lines[0] <= 1'b1;
      repeat (3) @(posedge clk);
   endtask
   // second counter of the split mode: direction on line 3, count pulse on line 2
   task automatic pulse1(input logic dir);
      @(posedge clk) lines[2] <= 1'b0;
      lines[3] <= dir;
      repeat (2) @(posedge clk);
      lines[2] <= 1'b1;
      repeat (3) @(posedge clk);
   endtask
endmodule

// >>> src/qec_counter.sv
// Decided for this implementation: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
module qec_counter (
   // clock and reset
   input wire logic CLK_SYS,
   input wire logic RESET,
   // avalon-mm slave
   input wire logic [4:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [3:0] AVS_BYTEENABLE,
   input wire logic [31:0] AVS_WRITEDATA,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   // field inputs
   input wire logic [7:0] DIN,
   // plain digital inputs seen by software
   output logic [7:0] DIG_IN,
   // setpoint interrupt request
   output logic IRQ_REQ,
   output logic [2:0] IRQ_SOURCE
);
   logic [31:0] config_q, config_d;
   logic [7:0] control_q, control_d;
   logic [31:0] ref_q, ref_d;
   logic [31:0] sp_q, sp_d;
   logic [31:0] cnt_q, cnt_d;
   logic done_q, done_d, zc0_q, zc0_d, zc1_q, zc1_d, err_q, err_d;
   logic [7:0] din_prev_q;
   logic [7:0] dig_q, dig_d;
   logic irq_q, irq_d;
   logic [2:0] irqsrc_q, irqsrc_d;
   logic wait_q, wait_d;
   logic [31:0] rdata_q, rdata_d;
   qec_pkg::qec_mode_t mode;
   logic window, mark_rise, a_chg, b_chg, qstep, qup;
   logic rise0, rise1, wr_ok, hit0, hit1;
   logic [31:0] status;
   logic [15:0] lo_n, hi_n;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // mode decode: every code is a legal mode
   always_comb begin
      unique case (config_q[qec_pkg::CFG_MODE_LSB +: 2])
         qec_pkg::MODE_CODE_DIG: mode = qec_pkg::QEC_DIG;
         qec_pkg::MODE_CODE_ENC: mode = qec_pkg::QEC_ENC;
         qec_pkg::MODE_CODE_C32: mode = qec_pkg::QEC_C32;
         qec_pkg::MODE_CODE_C16: mode = qec_pkg::QEC_C16;
      endcase
   end

   // window source; the unused code gives no window so a stray config cannot load
   always_comb begin
      unique case (config_q[qec_pkg::CFG_REFSRC_LSB +: 2])
         qec_pkg::REF_PERMANENT: window = 1'b1;
         qec_pkg::REF_SOFTWARE: window = control_q[qec_pkg::CTL_SW_WINDOW];
         qec_pkg::REF_HARDWARE: window = DIN[qec_pkg::PIN_WIN];
         default: window = 1'b0;
      endcase
   end

   // quadrature and pulse edge detection on the registered previous sample
   always_comb begin
      mark_rise = DIN[qec_pkg::PIN_MARK] & ~din_prev_q[qec_pkg::PIN_MARK];
      a_chg = DIN[qec_pkg::PIN_A] ^ din_prev_q[qec_pkg::PIN_A];
      b_chg = DIN[qec_pkg::PIN_B] ^ din_prev_q[qec_pkg::PIN_B];
      qstep = a_chg ^ b_chg;
      qup = DIN[qec_pkg::PIN_A] ^ din_prev_q[qec_pkg::PIN_B];
      rise0 = DIN[0] & ~din_prev_q[0];
      rise1 = DIN[2] & ~din_prev_q[2];
   end

   // counting core
   always_comb begin
      cnt_d = cnt_q;
      lo_n = cnt_q[15:0];
      hi_n = cnt_q[31:16];
      done_d = done_q;
      zc0_d = zc0_q & ~control_q[qec_pkg::CTL_ZC0_ACK];
      zc1_d = zc1_q & ~control_q[qec_pkg::CTL_ZC1_ACK];
      err_d = err_q & ~control_q[qec_pkg::CTL_ERR_ACK];
      hit0 = 1'b0;
      hit1 = 1'b0;
      unique case (mode)
         qec_pkg::QEC_DIG: begin
            cnt_d = cnt_q;
         end
         qec_pkg::QEC_ENC: begin
            if (control_q[qec_pkg::CTL_PRESET0]) begin
               cnt_d = ref_q;
            end else if (mark_rise && window) begin
               cnt_d = ref_q;
               done_d = 1'b1;
            end else if (control_q[qec_pkg::CTL_GATE0] && qstep) begin
               cnt_d = qup ? cnt_q + 32'h0000_0001 : cnt_q - 32'h0000_0001;
               if (cnt_d == 32'h0000_0000) begin
                  zc0_d = 1'b1;
               end
            end
            // set wins over a simultaneous ack
            if (control_q[qec_pkg::CTL_GATE0] && a_chg && b_chg) begin
               err_d = 1'b1;
            end
         end
         qec_pkg::QEC_C32: begin
            if (control_q[qec_pkg::CTL_PRESET0]) begin
               cnt_d = 32'h0000_0000;
            end else if (control_q[qec_pkg::CTL_GATE0] && rise0) begin
               cnt_d = DIN[1] ? cnt_q + 32'h0000_0001 : cnt_q - 32'h0000_0001;
               hit0 = (cnt_d == sp_q);
               if (cnt_d == 32'h0000_0000) begin
                  zc0_d = 1'b1;
               end
            end
         end
         qec_pkg::QEC_C16: begin
            if (control_q[qec_pkg::CTL_PRESET0]) begin
               lo_n = 16'h0000;
            end else if (control_q[qec_pkg::CTL_GATE0] && rise0) begin
               lo_n = DIN[1] ? cnt_q[15:0] + 16'h0001 : cnt_q[15:0] - 16'h0001;
               hit0 = (lo_n == sp_q[15:0]);
               if (lo_n == 16'h0000) begin
                  zc0_d = 1'b1;
               end
            end
            if (control_q[qec_pkg::CTL_PRESET1]) begin
               hi_n = 16'h0000;
            end else if (control_q[qec_pkg::CTL_GATE1] && rise1) begin
               hi_n = DIN[3] ? cnt_q[31:16] + 16'h0001 : cnt_q[31:16] - 16'h0001;
               hit1 = (hi_n == sp_q[31:16]);
               if (hi_n == 16'h0000) begin
                  zc1_d = 1'b1;
               end
            end
            cnt_d = {hi_n, lo_n};
         end
      endcase
      irq_d = hit0 | hit1;
      irqsrc_d = config_q[qec_pkg::CFG_IRQSRC_LSB +: 3];
      // inputs 0..3 belong to the counter outside digital mode
      dig_d = (mode == qec_pkg::QEC_DIG) ? DIN : {DIN[7:4], 4'h0};
   end

   always_comb begin
      status = 32'h0000_0000;
      status[qec_pkg::STS_REF_DONE] = done_q;
      status[qec_pkg::STS_ZC0] = zc0_q;
      status[qec_pkg::STS_ZC1] = zc1_q;
      status[qec_pkg::STS_ERR] = err_q;
      status[qec_pkg::STS_REF_ACTIVE] = (mode == qec_pkg::QEC_ENC) & window;
   end

   // bus slave: one wait cycle, then the answer at the edge where wait is low
   always_comb begin
      wr_ok = AVS_WRITE & ~wait_q;
      wait_d = ~((AVS_READ | AVS_WRITE) & wait_q);
      config_d = config_q;
      control_d = control_q;
      ref_d = ref_q;
      sp_d = sp_q;
      rdata_d = rdata_q;
      if (wr_ok) begin
         unique case (AVS_ADDRESS)
            qec_pkg::ADDR_CONFIG: config_d = merge(config_q, AVS_WRITEDATA, AVS_BYTEENABLE);
            qec_pkg::ADDR_CONTROL: begin
               if (AVS_BYTEENABLE[0]) begin
                  control_d = AVS_WRITEDATA[7:0];
               end
            end
            qec_pkg::ADDR_REF_VALUE: ref_d = merge(ref_q, AVS_WRITEDATA, AVS_BYTEENABLE);
            qec_pkg::ADDR_SETPOINT: sp_d = merge(sp_q, AVS_WRITEDATA, AVS_BYTEENABLE);
            default: begin
            end
         endcase
      end
      if (AVS_READ & wait_q) begin
         unique case (AVS_ADDRESS)
            qec_pkg::ADDR_CONFIG: rdata_d = {25'h0, config_q[6:0]};
            qec_pkg::ADDR_CONTROL: rdata_d = {24'h0, control_q};
            qec_pkg::ADDR_STATUS: rdata_d = status;
            qec_pkg::ADDR_COUNT_LO: rdata_d = {16'h0, cnt_q[15:0]};
            qec_pkg::ADDR_COUNT_HI: rdata_d = {16'h0, cnt_q[31:16]};
            qec_pkg::ADDR_REF_VALUE: rdata_d = ref_q;
            qec_pkg::ADDR_SETPOINT: rdata_d = sp_q;
            default: rdata_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         config_q <= qec_pkg::CONFIG_RESET;
         control_q <= qec_pkg::CONTROL_RESET;
         ref_q <= qec_pkg::REF_VALUE_RESET;
         sp_q <= qec_pkg::SETPOINT_RESET;
         cnt_q <= 32'h0000_0000;
         done_q <= 1'b0;
         zc0_q <= 1'b0;
         zc1_q <= 1'b0;
         err_q <= 1'b0;
         din_prev_q <= 8'h00;
         dig_q <= 8'h00;
         irq_q <= 1'b0;
         irqsrc_q <= 3'h0;
         wait_q <= 1'b1;
         rdata_q <= 32'h0000_0000;
      end else begin
         config_q <= config_d;
         control_q <= control_d;
         ref_q <= ref_d;
         sp_q <= sp_d;
         cnt_q <= cnt_d;
         done_q <= done_d;
         zc0_q <= zc0_d;
         zc1_q <= zc1_d;
         err_q <= err_d;
         din_prev_q <= DIN;
         dig_q <= dig_d;
         irq_q <= irq_d;
         irqsrc_q <= irqsrc_d;
         wait_q <= wait_d;
         rdata_q <= rdata_d;
      end
   end

   assign AVS_READDATA = rdata_q;
   assign AVS_WAITREQUEST = wait_q;
   assign DIG_IN = dig_q;
   assign IRQ_REQ = irq_q;
   assign IRQ_SOURCE = irqsrc_q;

   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (RESET);

   sequence enc_load_s;
      mode == qec_pkg::QEC_ENC && !control_q[qec_pkg::CTL_PRESET0] && mark_rise && window;
   endsequence
   sequence enc_step_s;
      mode == qec_pkg::QEC_ENC && !control_q[qec_pkg::CTL_PRESET0] && !(mark_rise && window)
         && control_q[qec_pkg::CTL_GATE0] && qstep;
   endsequence

   ref_load_a: assert property (enc_load_s |=> cnt_q == $past(ref_q) && done_q)
      else $error("reference load missed");
   preset_ref_a: assert property (
      mode == qec_pkg::QEC_ENC && control_q[qec_pkg::CTL_PRESET0] |=> cnt_q == $past(ref_q))
      else $error("encoder preset not reference value");
   quad_dir_a: assert property (
      enc_step_s |=> cnt_q == ($past(qup) ? $past(cnt_q) + 32'h1 : $past(cnt_q) - 32'h1))
      else $error("quadrature step wrong");
   gate_hold_a: assert property (
      mode != qec_pkg::QEC_DIG && !control_q[qec_pkg::CTL_GATE0]
      && !control_q[qec_pkg::CTL_GATE1] && !control_q[qec_pkg::CTL_PRESET0]
      && !control_q[qec_pkg::CTL_PRESET1] && !(mark_rise && window && mode == qec_pkg::QEC_ENC)
      |=> $stable(cnt_q))
      else $error("counted while gated");
   zc_set_a: assert property (enc_step_s ##1 cnt_q == 32'h0 |-> zc0_q)
      else $error("zero crossing not flagged");
   zc_ack_a: assert property (
      zc0_q && control_q[qec_pkg::CTL_ZC0_ACK] && !$rose(cnt_q == 32'h0)
      ##1 control_q[qec_pkg::CTL_ZC0_ACK] [*2] |-> !zc0_q)
      else $error("zero crossing ack ignored");
   err_set_a: assert property (
      mode == qec_pkg::QEC_ENC && control_q[qec_pkg::CTL_GATE0] && a_chg && b_chg |=> err_q)
      else $error("simultaneous edges not flagged");
   err_ack_a: assert property (
      err_q && control_q[qec_pkg::CTL_ERR_ACK] && !(a_chg && b_chg) |=> !err_q)
      else $error("error ack ignored");
   sp_irq_a: assert property (mode == qec_pkg::QEC_C32 && irq_q |-> cnt_q == sp_q)
      else $error("irq without setpoint match");
   dig_mask_a: assert property (
      mode != qec_pkg::QEC_DIG |=> DIG_IN[3:0] == 4'h0 && DIG_IN[7:4] == $past(DIN[7:4]))
      else $error("digital input masking wrong");
   bus_wait_a: assert property ((AVS_READ || AVS_WRITE) && wait_q |=> !wait_q ##1 wait_q)
      else $error("bus answer timing wrong");
   hw_window_a: assert property (
      mode == qec_pkg::QEC_ENC && config_q[qec_pkg::CFG_REFSRC_LSB +: 2] == qec_pkg::REF_HARDWARE
      |-> status[qec_pkg::STS_REF_ACTIVE] == DIN[qec_pkg::PIN_WIN])
      else $error("hardware window not shown");
   sw_window_a: assert property (
      mode == qec_pkg::QEC_ENC && config_q[qec_pkg::CFG_REFSRC_LSB +: 2] == qec_pkg::REF_SOFTWARE
      |-> status[qec_pkg::STS_REF_ACTIVE] == control_q[qec_pkg::CTL_SW_WINDOW])
      else $error("software window not shown");
   done_hold_a: assert property (done_q |=> done_q)
      else $error("reference done dropped");
   cnt_dir_a: assert property (
      mode == qec_pkg::QEC_C32 && !control_q[qec_pkg::CTL_PRESET0]
      && control_q[qec_pkg::CTL_GATE0] && rise0
      |=> cnt_q == ($past(DIN[1]) ? $past(cnt_q) + 32'h1 : $past(cnt_q) - 32'h1))
      else $error("counter direction wrong");
   half_preset_a: assert property (
      mode == qec_pkg::QEC_C16 && control_q[qec_pkg::CTL_PRESET1] |=> cnt_q[31:16] == 16'h0000)
      else $error("second counter preset wrong");
   irq_src_a: assert property (
      IRQ_SOURCE == $past(config_q[qec_pkg::CFG_IRQSRC_LSB +: 3]))
      else $error("interrupt source not passed on");
endmodule

// >>> src/qec_pkg.sv
// How it works
// - encoder mode takes inputs 0..3; inputs 4..7 stay plain inputs
// - encoder uses bit0 phase A, bit1 phase B, bit2 marker, bit3 window
// - window comes from input 3 or software window bit, by config; the code also has a permanent window, the reset setting
// - selected window high drives referencing-active status high
// - marker rising edge inside window loads counter with reference value
// - referencing-done flag goes high after a reference load
// - zero-crossing flag set when count passes zero, latched until acknowledged
// - software acknowledges zero crossing with ack bit; flag then clears
// - error flag rises when A and B edges coincide; the code sets it only while count gate 0 is high
// - software clears latched error with error ack bit
// - count shown as low word and high word registers
// - counter preset in encoder mode loads reference value, not zero
// - input pulses ignored while count gate low, counted while high
// - hardware window acts only in hardware mode, software bit only in software
// - inputs may instead form one 32-bit or two 16-bit up/down counters
// - counter mode holds a setpoint value and an interrupt source selection
// - counter mode raises interrupt request when count equals setpoint
// - counters take pulses on one input and direction on the next
package qec_pkg;
   localparam logic [4:0] ADDR_CONFIG = 5'h00;
   localparam logic [4:0] ADDR_CONTROL = 5'h04;
   localparam logic [4:0] ADDR_STATUS = 5'h08;
   localparam logic [4:0] ADDR_COUNT_LO = 5'h0c;
   localparam logic [4:0] ADDR_COUNT_HI = 5'h10;
   localparam logic [4:0] ADDR_REF_VALUE = 5'h14;
   localparam logic [4:0] ADDR_SETPOINT = 5'h18;
   // config fields
   localparam int CFG_MODE_LSB = 0;
   localparam int CFG_REFSRC_LSB = 2;
   localparam int CFG_IRQSRC_LSB = 4;
   localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
   // control bits
   localparam int CTL_SW_WINDOW = 0;
   localparam int CTL_PRESET0 = 1;
   localparam int CTL_PRESET1 = 2;
   localparam int CTL_ZC0_ACK = 3;
   localparam int CTL_ZC1_ACK = 4;
   localparam int CTL_ERR_ACK = 5;
   localparam int CTL_GATE0 = 6;
   localparam int CTL_GATE1 = 7;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   // status bits
   localparam int STS_REF_DONE = 0;
   localparam int STS_ZC0 = 1;
   localparam int STS_ZC1 = 2;
   localparam int STS_ERR = 3;
   localparam int STS_REF_ACTIVE = 4;
   localparam logic [31:0] REF_VALUE_RESET = 32'h0000_0000;
   localparam logic [31:0] SETPOINT_RESET = 32'hffff_ffff;
   // input pin positions
   localparam int PIN_A = 0;
   localparam int PIN_B = 1;
   localparam int PIN_MARK = 2;
   localparam int PIN_WIN = 3;
   localparam logic [1:0] MODE_CODE_DIG = 2'h0;
   localparam logic [1:0] MODE_CODE_ENC = 2'h1;
   localparam logic [1:0] MODE_CODE_C32 = 2'h2;
   localparam logic [1:0] MODE_CODE_C16 = 2'h3;
   localparam logic [1:0] REF_PERMANENT = 2'h0;
   localparam logic [1:0] REF_SOFTWARE = 2'h1;
   localparam logic [1:0] REF_HARDWARE = 2'h2;
   typedef enum logic [3:0] {
      QEC_DIG = 4'b0001,
      QEC_ENC = 4'b0010,
      QEC_C32 = 4'b0100,
      QEC_C16 = 4'b1000
   } qec_mode_t;
endpackage
